// ---- verilog/i2c_mem_slave.sv ----
// Serial memory slave: answers on a two-wire bus like a serial memory and
// turns its transfers into reads and buffered writes of a byte memory.
// Assumes both bus wires are open drain with pull-ups outside, and a
// memory that answers each read request with one acknowledge pulse.
`timescale 1ns/1ps
`include "i2c_mem_map.svh"

module i2c_mem_slave
  import i2c_mem_pkg::*;
#(
  parameter int         CLK_HZ   = `CLK_HZ,
  parameter logic [6:0] OWN_ADDR = `OWN_ADDR7
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic      [23:0] wr_addr,
  output logic      [7:0]  wr_data,
  output logic             rd_req,
  output logic      [23:0] rd_addr,
  input  wire logic        rd_ack,
  input  wire logic [7:0]  rd_data,
  output logic             master_not_acknowledge
);

  // ==========================================================================
  // Elaboration checks
  localparam int SCL_CYC = `FAST_SCL_NS * (CLK_HZ / 1000000) / 1000;
  if (SCL_CYC < `MIN_CYC_PER_SCL) begin : g_slow_clk
    $error("Clock too slow to follow a 400 kHz bus clock"); // RL1
  end

  // Address falls inside one of the two memory windows
  function automatic logic in_range(input logic [23:0] a);
    in_range = (a >= `PROG_LO && a <= `PROG_HI) ||
               (a >= `DATA_LO && a <= `DATA_HI);
  endfunction

  // ==========================================================================
  // Pin synchronisers and bus events
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  // Two flops per pin, then one more for edge detection
  always_ff @(posedge ref_clk) begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= sda_in;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s; // RL11
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================================
  // State
  slave_state_t state_reg;
  logic [7:0]   sh_reg;
  logic [3:0]   bit_cnt_reg;
  logic         rw_reg;
  logic [23:0]  ptr_reg;
  logic [7:0]   pend_reg [4];
  logic [2:0]   pend_cnt_reg;
  logic [2:0]   fl_idx_reg;
  logic         flush_reg;
  logic         over3_reg;
  logic         got_reg;
  logic [7:0]   rdbuf_reg;
  logic         buf_ready;

  // ==========================================================================
  // Decodes
  wire byte_done  = scl_fall & (bit_cnt_reg == 4'h8);
  wire addr_hit   = (sh_reg[7:1] == OWN_ADDR); // RL2
  wire in_write   = (state_reg == WR_BYTE) | (state_reg == WR_ACK);
  wire load_ptr   = start_ev & in_write & ~over3_reg & ~flush_reg &
                    (pend_cnt_reg == `ADDR_BYTES); // RL18
  wire end_write  = (start_ev | stop_ev) & in_write & ~load_ptr;
  wire append     = (state_reg == WR_BYTE) & byte_done & ~start_ev &
                    ~stop_ev;
  wire last_addr  = pend_cnt_reg == `ADDR_BYTES;
  wire flush_more = flush_reg & (fl_idx_reg != pend_cnt_reg);
  wire push_ok    = in_range(ptr_reg); // RL4
  wire buf_valid  = flush_more & push_ok; // RL5
  wire flush_step = flush_more & (~push_ok | buf_ready);
  wire [7:0] push_byte = pend_reg[fl_idx_reg[1:0]];
  wire rd_hit     = in_range(ptr_reg);
  wire rd_take    = (state_reg == RD_LOAD) & got_reg & ~scl_s;
  wire rd_want    = (state_reg == RD_LOAD) & rd_hit & ~got_reg;
  wire ack_stall  = ((state_reg == ADDR_ACK) | (state_reg == WR_ACK)) &
                    flush_reg;

  // ==========================================================================
  // Bus engine
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg   <= IDLE;
      sh_reg      <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (start_ev) begin
      state_reg   <= ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= IDLE;
      sda_oe    <= 1'b0;
    end else begin
      case (state_reg)
        ADDR, WR_BYTE: begin
          if (scl_rise) begin
            sh_reg      <= {sh_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == WR_BYTE) begin
              state_reg <= WR_ACK;
              sda_oe    <= 1'b1; // RL12
            end else if (addr_hit) begin
              state_reg <= ADDR_ACK;
              rw_reg    <= sh_reg[0]; // RL3
              sda_oe    <= 1'b1; // RL12
            end else begin
              state_reg <= IGNORE; // RL2
            end
          end
        end
        ADDR_ACK, WR_ACK: begin
          if (scl_fall) begin
            sda_oe    <= 1'b0;
            state_reg <= (state_reg == ADDR_ACK && rw_reg) ? RD_LOAD
                                                             : WR_BYTE;
          end
        end
        RD_LOAD: begin
          if (rd_take) begin
            sh_reg      <= rdbuf_reg;
            sda_oe      <= ~rdbuf_reg[7];
            bit_cnt_reg <= 4'h0;
            state_reg   <= RD_BYTE;
          end
        end
        RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            sda_oe    <= 1'b0;
            state_reg <= RD_ACK;
          end else if (scl_fall) begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            sda_oe <= ~sh_reg[6];
          end
        end
        RD_ACK: begin
          if (scl_rise) begin
            state_reg <= sda_s ? IGNORE : RD_LOAD; // RL13
          end
        end
        IDLE, IGNORE: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end

  // Not-acknowledge pulse at the end of a read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      master_not_acknowledge <= 1'b0;
    end else begin
      master_not_acknowledge <= (state_reg == RD_ACK) & scl_rise & sda_s &
                                ~start_ev & ~stop_ev; // RL13
    end
  end

  // Clock stretch while a read byte is fetched or written bytes drain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_oe <= 1'b0;
    end else begin
      scl_oe <= ~scl_s & ((state_reg == RD_LOAD) | ack_stall);
    end
  end

  // Both wires only ever pull low
  always_ff @(posedge ref_clk) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // ==========================================================================
  // Address pointer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr_reg <= `PTR_RESET; // RL6
    end else if (load_ptr) begin
      ptr_reg <= {pend_reg[0], pend_reg[1], pend_reg[2]}; // RL8 RL10
    end else if (flush_step | rd_take) begin
      ptr_reg <= ptr_reg + 24'h000001; // RL7
    end
  end

  // ==========================================================================
  // Received bytes wait here until they prove not to be an address
  always_ff @(posedge ref_clk) begin
    if (append) begin
      pend_reg[pend_cnt_reg[1:0]] <= sh_reg;
    end
  end

  // Pending count, drain index and drain control
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_cnt_reg <= 3'h0;
      fl_idx_reg   <= 3'h0;
      flush_reg    <= 1'b0;
      over3_reg    <= 1'b0;
    end else if (load_ptr) begin
      pend_cnt_reg <= 3'h0; // RL17
    end else if (append) begin
      pend_cnt_reg <= pend_cnt_reg + 3'h1;
      flush_reg    <= over3_reg | last_addr; // RL15
      over3_reg    <= over3_reg | last_addr;
    end else if (flush_reg & ~flush_more) begin
      flush_reg    <= 1'b0;
      pend_cnt_reg <= 3'h0;
      fl_idx_reg   <= 3'h0;
    end else begin
      if (flush_step) begin
        fl_idx_reg <= fl_idx_reg + 3'h1; // RL9
      end
      if (end_write & (pend_cnt_reg != 3'h0)) begin
        flush_reg <= 1'b1; // RL16
      end
      if (start_ev) begin
        over3_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read side: one request per byte inside the windows, at the present pointer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_req  <= 1'b0;
      rd_addr <= `PTR_RESET;
      got_reg <= 1'b0;
    end else begin
      rd_req <= rd_req ? ~rd_ack : rd_want; // RL9
      if (~rd_req) begin
        rd_addr <= ptr_reg;
      end
      if (start_ev | stop_ev | rd_take) begin
        got_reg <= 1'b0;
      end else if (state_reg == RD_LOAD & ~got_reg &
                   (~rd_hit | (rd_req & rd_ack))) begin
        got_reg <= 1'b1;
      end
    end
  end

  // Fetched byte, or all ones outside the windows
  always_ff @(posedge ref_clk) begin
    if (state_reg == RD_LOAD & ~got_reg) begin
      rdbuf_reg <= rd_hit ? rd_data : `EMPTY_BYTE;
    end
  end

  // ==========================================================================
  // Write buffer toward the memory
  skid_pair_buffer #(.WIDTH(32)) u_wbuf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   ({ptr_reg, push_byte}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  // ==========================================================================
  // Checks
  a_reset_ptr: assert property (@(posedge ref_clk) // RL6
    $fell(sys_rst) |-> ptr_reg == `PTR_RESET)
    else $error("Pointer not at data memory start after reset");

  a_own_ack: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL3
    state_reg == ADDR && byte_done && addr_hit && !start_ev && !stop_ev
    |=> sda_oe && state_reg == ADDR_ACK)
    else $error("Own address not acknowledged");

  a_foreign_skip: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
    state_reg == ADDR && byte_done && !addr_hit && !start_ev && !stop_ev
    |=> !sda_oe && state_reg == IGNORE)
    else $error("Foreign address byte not ignored");

  a_data_ack: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
    append |=> sda_oe ##1 (sda_oe || scl_fall || start_ev || stop_ev))
    else $error("Written byte not acknowledged");

  a_ptr_step: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
    (flush_step || rd_take) |=> ptr_reg == $past(ptr_reg) + 24'h000001)
    else $error("Pointer did not step by one");

  a_ptr_load: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL17
    load_ptr |=> ptr_reg == {$past(pend_reg[0]), $past(pend_reg[1]),
                             $past(pend_reg[2])} && pend_cnt_reg == 3'h0)
    else $error("Pointer not loaded from three address bytes");

  a_nack_end: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
    master_not_acknowledge |-> state_reg == IGNORE && !sda_oe)
    else $error("Data line held after master not-acknowledge");

  a_write_range: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL4
    wr_valid |-> in_range(wr_addr))
    else $error("Write issued outside the memory windows");

  a_read_range: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
    rd_req |-> in_range(rd_addr))
    else $error("Read issued outside the memory windows");

  a_read_addr: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL9
    $rose(rd_req) |-> rd_addr == ptr_reg)
    else $error("Read not issued at the present pointer");

  c_ptr_load: cover property (@(posedge ref_clk) disable iff (sys_rst)
    load_ptr);
  c_block_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
    over3_reg && flush_step);
  c_read_end: cover property (@(posedge ref_clk) disable iff (sys_rst)
    master_not_acknowledge);

endmodule

// ---- common/i2c_mem_map.svh ----
// Constants of the serial memory slave: bus address, memory windows,
// pointer reset value and bus timing figures.
// Assumes inclusion by the slave module and the bench only.
//
// Summary of operation
// RL1: Seven-bit addressing; works with bus clocks of 100 kHz and 400 kHz.
// RL2: Ten-bit addressing is not supported; foreign address bytes are ignored.
// RL3: Own address byte A2h, bit 0 is direction; seven-bit address 51h.
// RL4: Program memory window 8000h to 27FFFh is readable and writable.
// RL5: Data memory window 4000h to 47FFh is readable and writable.
// RL6: Reset leaves the address pointer at 4000h.
// RL7: Pointer steps by one for every data byte read or written.
// RL8: Address arrives as three bytes, most significant first.
// RL9: Current read or write starts at the present pointer.
// RL10: Random command loads the pointer first, then accesses from there.
// RL11: Master makes every start and stop and sets direction correctly.
// RL12: Slave acknowledges its address and every byte it receives.
// RL13: Master not-acknowledge ends a read; slave releases the data line.
// RL14: Master reads between 1 and 255 bytes per transaction.
// RL15: Single bytes, words or whole blocks may be written.
// RL16: Random access sends address without stop, then a repeated start.
// RL17: After the address phase the pointer holds the received address.
// RL18: Three bytes then repeated start load the pointer; else bytes are stored.
`ifndef I2C_MEM_MAP_SVH
`define I2C_MEM_MAP_SVH

// ==========================================================================
// Bus address
`define OWN_ADDR_BYTE   8'ha2
`define OWN_ADDR7       7'h51

// ==========================================================================
// Memory windows and pointer
`define PROG_LO         24'h008000
`define PROG_HI         24'h027fff
`define DATA_LO         24'h004000
`define DATA_HI         24'h0047ff
`define PTR_RESET       24'h004000
`define ADDR_BYTES      3'h3
`define EMPTY_BYTE      8'hff

// ==========================================================================
// Timing
`define CLK_HZ          40000000
`define STD_SCL_HZ      100000
`define FAST_SCL_HZ     400000
`define FAST_SCL_NS     2500
`define MIN_CYC_PER_SCL 16

`endif

// ---- common/i2c_mem_pkg.sv ----
// Types shared by the serial memory slave.
// Assumes nothing of its surroundings.
package i2c_mem_pkg;

  // ==========================================================================
  // Bus engine states
  typedef enum logic [3:0] {
    IDLE, ADDR, ADDR_ACK, WR_BYTE, WR_ACK, RD_LOAD, RD_BYTE, RD_ACK, IGNORE
  } slave_state_t;

endpackage

// ---- verilog/skid_pair_buffer.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module skid_pair_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  if (WIDTH < 1) begin : g_bad_width
    $error("Buffer width must be at least one");
  end

  logic             spare_v_reg;
  logic [WIDTH-1:0] spare_d_reg;
  wire              push = in_valid & in_ready;
  wire              free = ~out_valid | out_ready;

  // ==========================================================================
  // Output slot and spare slot; ready falls while the spare is held
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid   <= 1'b0;
      spare_v_reg <= 1'b0;
    end else if (free) begin
      out_valid   <= spare_v_reg | push;
      spare_v_reg <= 1'b0;
    end else if (push) begin
      spare_v_reg <= 1'b1;
    end
  end

  // Data paths follow the valid bits
  always_ff @(posedge ref_clk) begin
    if (free) begin
      out_data <= spare_v_reg ? spare_d_reg : in_data;
    end
    if (push & ~free) begin
      spare_d_reg <= in_data;
    end
  end

  // Ready is the spare slot being empty
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= ~((spare_v_reg & ~free) | (push & ~free));
    end
  end

endmodule

// ---- verification/i2c_master_model.sv ----
// Bus master model: drives clock and data open drain at 400 kHz.
// Assumes the bench resolves both wires with pull-ups and feeds them back.
`timescale 1ns/1ps

module i2c_master_model (
  input  wire logic ref_clk,
  input  wire logic scl_wire,
  input  wire logic sda_wire,
  output logic      scl_low,
  output logic      sda_low
);
  // ==========================================================================
  // Bus timing
  localparam int QTR = 25;
  int stalls;

  // Both wires released at time zero
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls  = 0;
  end

  task automatic wait_q();
    repeat (QTR) @(posedge ref_clk);
  endtask

  // Release the clock, then wait out any stretch by the slave
  task automatic rise_scl();
    int n;
    n = 0;
    scl_low <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scl_wire !== 1'b1 && n < 20000);
    // A stretch that never ends is counted for the bench
    if (n >= 20000) stalls++;
    wait_q();
  endtask

  // ==========================================================================
  // Bit, condition and byte tasks
  task automatic bit_io(input logic b, output logic r);
    wait_q();
    sda_low <= ~b;
    wait_q();
    rise_scl();
    r = sda_wire;
    wait_q();
    scl_low <= 1'b1;
  endtask

  // Start, also usable as repeated start after a byte
  task automatic send_start();
    wait_q();
    sda_low <= 1'b0;
    wait_q();
    rise_scl();
    sda_low <= 1'b1;
    wait_q();
    scl_low <= 1'b1;
  endtask

  task automatic send_stop();
    wait_q();
    sda_low <= 1'b1;
    wait_q();
    rise_scl();
    sda_low <= 1'b0;
    wait_q();
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read is left unacknowledged
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ---- verification/i2c_eeprom_style_memory_slave_bench.sv ----
// Self-checking bench of the serial memory slave with a master model.
// Assumes pull-ups on both wires and a byte memory modelled here.
`timescale 1ns/1ps
`include "i2c_mem_map.svh"

module i2c_eeprom_style_memory_slave_bench;
  typedef struct {
    logic        rd;
    logic        rand_acc;
    logic        slow;
    logic [23:0] addr;
    int          len;
    logic [7:0]  wbase;
    int          exp_wr;
  } row_t;

  logic        ref_clk, sys_rst, slow;
  logic        scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low;
  logic        wr_valid, wr_ready, rd_req, rd_ack, master_not_acknowledge;
  logic [23:0] wr_addr, rd_addr, ptr;
  logic [7:0]  wr_data, rd_data, mem [logic [23:0]], exp_mem [logic [23:0]];
  logic [4:0]  cyc;
  wire         scl_wire, sda_wire;
  int          num_errors, check_count, wr_count, nack_count, rd_wait;
  int          reads;
  row_t        rows [10];

  // Open-drain wires with pull-ups
  assign scl_wire = ~scl_low & ~(scl_oe & ~scl_out);
  assign sda_wire = ~sda_low & ~(sda_oe & ~sda_out);

  i2c_mem_slave i_i2c_mem_slave (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .scl_in(scl_wire), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data),
    .master_not_acknowledge(master_not_acknowledge));

  i2c_master_model i_i2c_master_model (.ref_clk(ref_clk),
    .scl_wire(scl_wire), .sda_wire(sda_wire),
    .scl_low(scl_low), .sda_low(sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] pat(logic [23:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  function automatic logic in_range(logic [23:0] a);
    return (a >= `PROG_LO && a <= `PROG_HI) ||
           (a >= `DATA_LO && a <= `DATA_HI);
  endfunction

  function automatic logic [7:0] expect_byte(logic [23:0] a);
    if (!in_range(a)) return `EMPTY_BYTE;
    return exp_mem.exists(a) ? exp_mem[a] : pat(a);
  endfunction

  // ==========================================================================
  // Memory model: stalling write sink and slow or prompt read port
  always @(posedge ref_clk) begin
    cyc <= cyc + 5'h01;
    wr_ready <= !slow || cyc == 5'h00;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      mem[wr_addr] = wr_data;
      wr_count++;
    end
    if (master_not_acknowledge === 1'b1) nack_count++;
    // One assignment per signal and edge: answer, or idle with noise
    if (rd_req === 1'b1 && rd_ack !== 1'b1 &&
        rd_wait >= (slow ? 40 : 0)) begin
      rd_ack  <= 1'b1;
      rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : pat(rd_addr);
      rd_wait <= 0;
    end else begin
      rd_ack  <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req === 1'b1 && rd_ack !== 1'b1) rd_wait <= rd_wait + 1;
    end
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("idle", {4'h0, scl_oe, sda_oe, wr_valid, rd_req}, 8'h00);
    ptr = `DATA_LO;
  endtask

  // One transfer: optional pointer load, then reads or writes
  task automatic run_row(row_t r);
    logic       ack;
    logic [7:0] d;
    int         base;
    base = wr_count;
    slow <= r.slow;
    if (r.rand_acc) begin
      i_i2c_master_model.send_start();
      i_i2c_master_model.write_byte(`OWN_ADDR_BYTE, ack);
      check("addr ack", 8'(ack), 8'h01);
      for (int i = 2; i >= 0; i--) begin
        i_i2c_master_model.write_byte(r.addr[8*i +: 8], ack);
        check("ptr ack", 8'(ack), 8'h01);
      end
      ptr = r.addr;
    end
    i_i2c_master_model.send_start();
    i_i2c_master_model.write_byte(`OWN_ADDR_BYTE | {7'h0, r.rd}, ack);
    check("dev ack", 8'(ack), 8'h01);
    for (int i = 0; i < r.len; i++) begin
      if (r.rd) begin
        i_i2c_master_model.read_byte(i == r.len - 1, d);
        check("read data", d, expect_byte(ptr));
      end else begin
        i_i2c_master_model.write_byte(r.wbase + 8'(i), ack);
        check("write ack", 8'(ack), 8'h01);
        if (in_range(ptr)) exp_mem[ptr] = r.wbase + 8'(i);
      end
      ptr++;
    end
    if (r.rd) reads++;
    if (r.rd) check("released", 8'(sda_oe), 8'h00);
    i_i2c_master_model.send_stop();
    for (int n = 0; n < 2000 && wr_count != base + r.exp_wr; n++)
      @(posedge ref_clk);
    check("words", 8'(wr_count - base), 8'(r.exp_wr));
  endtask

  // Watchdog
  initial begin
    repeat (95000) @(posedge ref_clk);
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic ack;
    sys_rst = 1'b1;
    slow = 1'b0;
    wr_ready = 1'b0;
    rd_ack = 1'b0;
    rd_data = 8'h00;
    cyc = 5'h00;
    rows = '{
      '{1'b1, 1'b0, 1'b0, 24'h000000, 2, 8'h00, 0},
      '{1'b0, 1'b0, 1'b1, 24'h000000, 2, 8'h10, 2},
      '{1'b0, 1'b1, 1'b1, 24'h008000, 4, 8'h20, 4},
      '{1'b1, 1'b1, 1'b1, 24'h007ffe, 3, 8'h00, 0},
      '{1'b0, 1'b1, 1'b0, 24'h0047ff, 2, 8'h30, 1},
      '{1'b1, 1'b1, 1'b0, 24'h0047fe, 3, 8'h00, 0},
      '{1'b1, 1'b1, 1'b0, 24'h004000, 4, 8'h00, 0},
      '{1'b0, 1'b0, 1'b0, 24'h000000, 3, 8'h40, 3},
      '{1'b1, 1'b1, 1'b0, 24'h004004, 3, 8'h00, 0},
      '{1'b1, 1'b1, 1'b1, 24'h027ffe, 3, 8'h00, 0}};
    do_reset();
    foreach (rows[k]) run_row(rows[k]);
    // Foreign and ten-bit address bytes are not acknowledged
    i_i2c_master_model.send_start();
    i_i2c_master_model.write_byte(8'ha0, ack);
    check("foreign ack", 8'(ack), 8'h00);
    i_i2c_master_model.send_start();
    i_i2c_master_model.write_byte(8'hf0, ack);
    check("ten bit ack", 8'(ack), 8'h00);
    i_i2c_master_model.send_stop();
    check("nack pulses", 8'(nack_count), 8'(reads));
    // Reset in mid-run returns the pointer to the data window start
    do_reset();
    run_row(row_t'{1'b1, 1'b0, 1'b0, 24'h000000, 2, 8'h00, 0});
    check("stalls", 8'(i_i2c_master_model.stalls), 8'h00);
    print_verdict();
  end
endmodule
